// >>> core/tsg_pkg.sv
// Contract
// - Timeout disabled: clock held low never resets the serial interface.
// - Timeout enabled: clock low longer than 30 ms resets the serial interface; the code restarts the count on any data-line edge.
// - Timeout enabled: both lines high over 200 us resets; disabled: never.
// - Noise threshold in use: deltas above noise, not above touch, skip recalibration.
// - Noise threshold off: every delta not above touch feeds recalibration.
// - Low-frequency filter on: detected low-frequency noise forces delta to zero.
// - Held-touch recalibration on: touch held past maximum duration restarts recalibration.
// - Base out of limit with retry set repeats calibration, else keeps base.
// - Power gate control clear: reduced power from last conversion to cycle end.
// - Base-limit flag raises an interrupt only when its enable is set.
// - RF-only option set: noise status shows only RF noise.
// - RF filter on: detected RF noise forces delta to zero.
// - Calibration-failure flag raises an interrupt only when its enable is set.
// - Release interrupt suppressed when set; press and repeat interrupts always.
// - Six enable bits include or exclude each input; all set at reset.
// - Maximum-duration code decodes to the sixteen listed millisecond values.
// - Repeat interrupts spaced by (code+1) times 35 ms.
package tsg_pkg;

  // Register offsets.
  localparam logic [7:0] GLOBAL_CONFIG_ADDR = 8'h20;
  localparam logic [7:0] ACTIVE_INPUT_ENABLE_ADDR = 8'h21;
  localparam logic [7:0] TOUCH_TIMING_CONFIG_ADDR = 8'h22;
  localparam logic [7:0] GLOBAL_CONFIG_SECOND_ADDR = 8'h44;

  // Reset values and writable masks.
  localparam logic [7:0] GLOBAL_CONFIG_RESET = 8'h20;
  localparam logic [7:0] GLOBAL_CONFIG_MASK = 8'hb8;
  localparam logic [7:0] ACTIVE_INPUT_ENABLE_RESET = 8'h3f;
  localparam logic [7:0] ACTIVE_INPUT_ENABLE_MASK = 8'h3f;
  localparam logic [7:0] TOUCH_TIMING_CONFIG_RESET = 8'ha4;
  localparam logic [7:0] GLOBAL_CONFIG_SECOND_RESET = 8'h40;
  localparam logic [7:0] GLOBAL_CONFIG_SECOND_MASK = 8'h7f;

  // Field positions in global_config.
  localparam int BUS_TIMEOUT_ENABLE_BIT = 7;
  localparam int DIGITAL_NOISE_THRESHOLD_OFF_BIT = 5;
  localparam int LOWFREQ_FILTER_OFF_BIT = 4;
  localparam int HELD_TOUCH_RECAL_ENABLE_BIT = 3;

  // Field positions in global_config_second.
  localparam int BASE_LIMIT_RECAL_RETRY_BIT = 6;
  localparam int IDLE_POWER_GATE_OFF_BIT = 5;
  localparam int BASE_LIMIT_IRQ_ENABLE_BIT = 4;
  localparam int RF_ONLY_NOISE_REPORT_BIT = 3;
  localparam int RF_FILTER_OFF_BIT = 2;
  localparam int CAL_FAIL_IRQ_ENABLE_BIT = 1;
  localparam int RELEASE_IRQ_SUPPRESS_BIT = 0;

  // Field positions in touch_timing_config.
  localparam int MAX_HOLD_TIME_CODE_LSB = 4;
  localparam int REPEAT_INTERVAL_CODE_LSB = 0;

  // Channel count and counter widths.
  localparam int NUM_INPUTS = 6;
  localparam int MS_CNT_W = 18;
  localparam int HOLD_MS_W = 14;
  localparam int RPT_MS_W = 10;
  localparam int LOW_CNT_W = 23;
  localparam int IDLE_CNT_W = 16;

  // Timing figures and derived cycle counts.
  localparam int CLK_MHZ = 200;
  localparam int MS_TICK_US = 1000;
  localparam int BUS_LOW_TIMEOUT_MS = 30;
  localparam int BUS_IDLE_US = 200;
  localparam int REPEAT_STEP_MS = 35;
  localparam int MS_TICK_CYCLES = MS_TICK_US * CLK_MHZ;
  localparam int BUS_LOW_TIMEOUT_CYCLES = BUS_LOW_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int BUS_IDLE_CYCLES = BUS_IDLE_US * CLK_MHZ;

  // Maximum hold time in milliseconds for each code.
  function automatic logic [HOLD_MS_W-1:0] max_hold_ms(input logic [3:0] code);
    logic [HOLD_MS_W-1:0] ms;
    ms = 14'h0230;
    case (code)
      4'h0: ms = 14'h0230;
      4'h1: ms = 14'h0348;
      4'h2: ms = 14'h0460;
      4'h3: ms = 14'h0578;
      4'h4: ms = 14'h0690;
      4'h5: ms = 14'h08c0;
      4'h6: ms = 14'h0af0;
      4'h7: ms = 14'h0d20;
      4'h8: ms = 14'h0f50;
      4'h9: ms = 14'h1180;
      4'ha: ms = 14'h15e0;
      4'hb: ms = 14'h1a40;
      4'hc: ms = 14'h1ea0;
      4'hd: ms = 14'h22ca;
      4'he: ms = 14'h2760;
      default: ms = 14'h2bc0;
    endcase
    return ms;
  endfunction

  // Repeat interval in milliseconds for each code.
  function automatic logic [RPT_MS_W-1:0] repeat_ms(input logic [3:0] code);
    return ({6'h00, code} + 10'h001) * RPT_MS_W'(REPEAT_STEP_MS);
  endfunction

endpackage

// >>> core/tsg_line_watch.sv
`timescale 1ns/1ps
module tsg_line_watch #(
  parameter int unsigned P_LOW_CYCLES = tsg_pkg::BUS_LOW_TIMEOUT_CYCLES,
  parameter int unsigned P_IDLE_CYCLES = tsg_pkg::BUS_IDLE_CYCLES
) (
  input wire logic i_clk,    // System clock.
  input wire logic i_rst_n,  // Synchronised reset, active low.
  input wire logic i_ce,     // Clock enable.
  input wire logic i_enable, // Timeout and idle detection enable.
  input wire logic i_scl,    // Bus clock line level.
  input wire logic i_sda,    // Bus data line level.
  output logic o_reset       // One-cycle serial interface reset.
);

  typedef struct packed {
    logic scl;
    logic sda;
    logic [tsg_pkg::LOW_CNT_W-1:0] low_cnt;
    logic [tsg_pkg::IDLE_CNT_W-1:0] idle_cnt;
    logic rst;
  } tsg_watch_t;

  tsg_watch_t s;
  tsg_watch_t next_s;
  logic edge_seen;

  // Counters restart on any edge and fire once when the level has stood long enough.
  always_comb begin
    next_s = s;
    next_s.scl = i_scl;
    next_s.sda = i_sda;
    next_s.rst = 1'b0;
    edge_seen = (i_scl != s.scl) || (i_sda != s.sda);
    if (!i_enable || edge_seen || i_scl) begin
      next_s.low_cnt = '0;
    end else if (s.low_cnt != tsg_pkg::LOW_CNT_W'(P_LOW_CYCLES + 1)) begin
      next_s.low_cnt = s.low_cnt + 1'b1;
      next_s.rst = (s.low_cnt == tsg_pkg::LOW_CNT_W'(P_LOW_CYCLES));
    end
    if (!i_enable || edge_seen || !(i_scl && i_sda)) begin
      next_s.idle_cnt = '0;
    end else if (s.idle_cnt != tsg_pkg::IDLE_CNT_W'(P_IDLE_CYCLES + 1)) begin
      next_s.idle_cnt = s.idle_cnt + 1'b1;
      next_s.rst = next_s.rst || (s.idle_cnt == tsg_pkg::IDLE_CNT_W'(P_IDLE_CYCLES));
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign o_reset = s.rst;

  a_off_no_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && !i_enable) |=> !o_reset)
    else $error("interface reset while timeout disabled");

  a_low_timeout: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && i_enable && s.low_cnt == tsg_pkg::LOW_CNT_W'(P_LOW_CYCLES) && !i_scl && !s.scl && i_sda == s.sda)
    |=> o_reset)
    else $error("clock low timeout did not reset interface");

  a_edge_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && (i_scl != s.scl)) |=> (s.low_cnt == '0 && s.idle_cnt == '0 && !o_reset))
    else $error("line edge did not restart counters");

endmodule

// >>> core/tsg_top.sv
`timescale 1ns/1ps
module tsg_top #(
  parameter int unsigned P_MS_CYCLES = tsg_pkg::MS_TICK_CYCLES,
  parameter int unsigned P_LOW_CYCLES = tsg_pkg::BUS_LOW_TIMEOUT_CYCLES,
  parameter int unsigned P_IDLE_CYCLES = tsg_pkg::BUS_IDLE_CYCLES
) (
  input wire logic i_clk,                 // System clock, 200 MHz.
  input wire logic i_rstn,                // Asynchronous reset, active low.
  input wire logic i_ce,                  // Clock enable, freezes all state but the reset synchroniser when low.
  input wire logic [7:0] i_reg_addr,      // Register offset.
  input wire logic i_reg_wr,              // Register write strobe.
  input wire logic [7:0] i_reg_wdata,     // Register write data.
  input wire logic i_reg_rd,              // Register read strobe.
  output logic [7:0] o_reg_rdata,         // Register read data, one cycle after strobe.
  input wire logic i_scl,                 // Bus clock line level.
  input wire logic i_sda,                 // Bus data line level.
  output logic o_bus_reset,               // Serial interface reset pulse.
  input wire logic [5:0] i_conv_done,     // Per-input conversion result strobe.
  input wire logic [47:0] i_raw_delta,    // Per-input signed raw delta, input 1 low.
  input wire logic [5:0] i_lf_noise,      // Per-input low-frequency noise detected.
  input wire logic [5:0] i_rf_noise,      // Per-input RF noise detected.
  input wire logic [7:0] i_touch_thr,     // Signed touch threshold.
  input wire logic [7:0] i_noise_thr,     // Signed digital noise threshold.
  input wire logic [5:0] i_base_limit_set,// Per-input base-limit flag set pulse.
  input wire logic i_cal_fail_set,        // Calibration failure flag set pulse.
  input wire logic i_last_conv_done,      // Last conversion of the cycle finished.
  input wire logic i_cycle_end,           // Sensing cycle ended.
  output logic [47:0] o_delta,            // Filtered per-input delta.
  output logic [5:0] o_noise_status,      // Per-input noise status.
  output logic [5:0] o_touch,             // Per-input touch level.
  output logic [5:0] o_recal_sample,      // Sample fed to automatic recalibration.
  output logic [5:0] o_hold_recal,        // Held-touch recalibration restart pulse.
  output logic [5:0] o_cal_retry,         // Analog calibration retry pulse.
  output logic [5:0] o_active_enable,     // Inputs included in the Active cycle.
  output logic o_irq_req,                 // Interrupt request pulse.
  output logic o_low_power                // Reduced power level.
);

  typedef struct packed {
    logic [7:0] gcfg;
    logic [5:0] en;
    logic [7:0] timing;
    logic [7:0] gcfg2;
    logic [7:0] rdata;
    logic [tsg_pkg::MS_CNT_W-1:0] ms_cnt;
    logic tick;
    logic [5:0][7:0] delta;
    logic [5:0] noise;
    logic [5:0] touched;
    logic [5:0][tsg_pkg::HOLD_MS_W-1:0] hold_ms;
    logic [5:0][tsg_pkg::RPT_MS_W-1:0] rpt_ms;
    logic [5:0] recal_sample;
    logic [5:0] hold_recal;
    logic [5:0] retry;
    logic irq;
    logic lowp;
  } tsg_state_t;

  tsg_state_t s;
  tsg_state_t next_s;
  logic [1:0] rst_sync;
  logic rst_n;

  // Reset release through two flip-flops.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Named views of the configuration fields.
  logic bus_timeout_enable;
  logic digital_noise_threshold_off;
  logic lowfreq_filter_off;
  logic held_touch_recal_enable;
  logic base_limit_recal_retry;
  logic idle_power_gate_off;
  logic base_limit_irq_enable;
  logic rf_only_noise_report;
  logic rf_filter_off;
  logic cal_fail_irq_enable;
  logic release_irq_suppress;
  logic [3:0] max_hold_time_code;
  logic [3:0] repeat_interval_code;
  logic [tsg_pkg::HOLD_MS_W-1:0] hold_limit_ms;
  logic [tsg_pkg::RPT_MS_W-1:0] repeat_period_ms;

  assign bus_timeout_enable = s.gcfg[tsg_pkg::BUS_TIMEOUT_ENABLE_BIT];
  assign digital_noise_threshold_off = s.gcfg[tsg_pkg::DIGITAL_NOISE_THRESHOLD_OFF_BIT];
  assign lowfreq_filter_off = s.gcfg[tsg_pkg::LOWFREQ_FILTER_OFF_BIT];
  assign held_touch_recal_enable = s.gcfg[tsg_pkg::HELD_TOUCH_RECAL_ENABLE_BIT];
  assign base_limit_recal_retry = s.gcfg2[tsg_pkg::BASE_LIMIT_RECAL_RETRY_BIT];
  assign idle_power_gate_off = s.gcfg2[tsg_pkg::IDLE_POWER_GATE_OFF_BIT];
  assign base_limit_irq_enable = s.gcfg2[tsg_pkg::BASE_LIMIT_IRQ_ENABLE_BIT];
  assign rf_only_noise_report = s.gcfg2[tsg_pkg::RF_ONLY_NOISE_REPORT_BIT];
  assign rf_filter_off = s.gcfg2[tsg_pkg::RF_FILTER_OFF_BIT];
  assign cal_fail_irq_enable = s.gcfg2[tsg_pkg::CAL_FAIL_IRQ_ENABLE_BIT];
  assign release_irq_suppress = s.gcfg2[tsg_pkg::RELEASE_IRQ_SUPPRESS_BIT];
  assign max_hold_time_code = s.timing[tsg_pkg::MAX_HOLD_TIME_CODE_LSB +: 4];
  assign repeat_interval_code = s.timing[tsg_pkg::REPEAT_INTERVAL_CODE_LSB +: 4];

  // Decoded hold limit and repeat period.
  assign hold_limit_ms = tsg_pkg::max_hold_ms(max_hold_time_code);
  assign repeat_period_ms = tsg_pkg::repeat_ms(repeat_interval_code);

  // Next-state logic: registers, millisecond tick and per-input touch handling.
  always_comb begin
    logic [7:0] filt;
    logic blocked;
    logic above_touch;
    logic above_noise;
    filt = 8'h00;
    blocked = 1'b0;
    above_touch = 1'b0;
    above_noise = 1'b0;
    next_s = s;
    next_s.irq = 1'b0;
    next_s.recal_sample = '0;
    next_s.hold_recal = '0;
    next_s.tick = 1'b0;

    // Millisecond time base for hold and repeat timing.
    if (s.ms_cnt == tsg_pkg::MS_CNT_W'(P_MS_CYCLES - 1)) begin
      next_s.ms_cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.ms_cnt = s.ms_cnt + 1'b1;
    end

    // Register writes; reserved bits stay zero.
    if (i_reg_wr) begin
      case (i_reg_addr)
        tsg_pkg::GLOBAL_CONFIG_ADDR: next_s.gcfg = i_reg_wdata & tsg_pkg::GLOBAL_CONFIG_MASK;
        tsg_pkg::ACTIVE_INPUT_ENABLE_ADDR: next_s.en = i_reg_wdata[5:0];
        tsg_pkg::TOUCH_TIMING_CONFIG_ADDR: next_s.timing = i_reg_wdata;
        tsg_pkg::GLOBAL_CONFIG_SECOND_ADDR: next_s.gcfg2 = i_reg_wdata & tsg_pkg::GLOBAL_CONFIG_SECOND_MASK;
        default: next_s.gcfg = s.gcfg;
      endcase
    end

    // Register reads; unmapped offsets read zero.
    if (i_reg_rd) begin
      case (i_reg_addr)
        tsg_pkg::GLOBAL_CONFIG_ADDR: next_s.rdata = s.gcfg;
        tsg_pkg::ACTIVE_INPUT_ENABLE_ADDR: next_s.rdata = {2'b00, s.en};
        tsg_pkg::TOUCH_TIMING_CONFIG_ADDR: next_s.rdata = s.timing;
        tsg_pkg::GLOBAL_CONFIG_SECOND_ADDR: next_s.rdata = s.gcfg2;
        default: next_s.rdata = 8'h00;
      endcase
    end

    for (int i = 0; i < tsg_pkg::NUM_INPUTS; i++) begin
      // Hold and repeat timers advance each millisecond while touched.
      if (s.tick && s.touched[i]) begin
        if (s.hold_ms[i] != '1) begin
          next_s.hold_ms[i] = s.hold_ms[i] + 1'b1;
        end
        if (held_touch_recal_enable && s.hold_ms[i] == hold_limit_ms) begin
          next_s.hold_recal[i] = 1'b1;
        end
        if (s.rpt_ms[i] + 1'b1 == repeat_period_ms) begin
          next_s.rpt_ms[i] = '0;
          next_s.irq = 1'b1;
        end else begin
          next_s.rpt_ms[i] = s.rpt_ms[i] + 1'b1;
        end
      end

      if (!s.en[i]) begin
        // Excluded inputs take no samples and report no touch.
        next_s.touched[i] = 1'b0;
      end else if (i_conv_done[i]) begin
        blocked = (i_lf_noise[i] && !lowfreq_filter_off) || (i_rf_noise[i] && !rf_filter_off);
        filt = blocked ? 8'h00 : i_raw_delta[i*8 +: 8];
        next_s.delta[i] = filt;
        next_s.noise[i] = i_rf_noise[i] || (i_lf_noise[i] && !rf_only_noise_report);
        above_touch = $signed(filt) > $signed(i_touch_thr);
        above_noise = $signed(filt) > $signed(i_noise_thr);
        next_s.recal_sample[i] = !above_touch && (digital_noise_threshold_off || !above_noise);
        next_s.touched[i] = above_touch;
        if (above_touch && !s.touched[i]) begin
          next_s.irq = 1'b1;
          next_s.hold_ms[i] = '0;
          next_s.rpt_ms[i] = '0;
        end
        if (!above_touch && s.touched[i] && !release_irq_suppress) begin
          next_s.irq = 1'b1;
        end
      end
    end

    // Base-limit retry and flag interrupts.
    next_s.retry = i_base_limit_set & {6{base_limit_recal_retry}};
    if ((|i_base_limit_set && base_limit_irq_enable) || (i_cal_fail_set && cal_fail_irq_enable)) begin
      next_s.irq = 1'b1;
    end

    // Reduced power between the last conversion and the cycle end.
    if (idle_power_gate_off || i_cycle_end) begin
      next_s.lowp = 1'b0;
    end else if (i_last_conv_done) begin
      next_s.lowp = 1'b1;
    end
  end

  // State register with reset values, frozen while the clock enable is low.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.gcfg <= tsg_pkg::GLOBAL_CONFIG_RESET;
      s.en <= tsg_pkg::ACTIVE_INPUT_ENABLE_RESET[5:0];
      s.timing <= tsg_pkg::TOUCH_TIMING_CONFIG_RESET;
      s.gcfg2 <= tsg_pkg::GLOBAL_CONFIG_SECOND_RESET;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  // Serial line watchdog.
  tsg_line_watch #(
    .P_LOW_CYCLES(P_LOW_CYCLES),
    .P_IDLE_CYCLES(P_IDLE_CYCLES)
  ) u_line_watch (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_enable(bus_timeout_enable),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_reset(o_bus_reset)
  );

  // Outputs straight from the state register.
  assign o_reg_rdata = s.rdata;
  assign o_delta = s.delta;
  assign o_noise_status = s.noise;
  assign o_touch = s.touched;
  assign o_recal_sample = s.recal_sample;
  assign o_hold_recal = s.hold_recal;
  assign o_cal_retry = s.retry;
  assign o_active_enable = s.en;
  assign o_irq_req = s.irq;
  assign o_low_power = s.lowp;

  // Base-limit interrupt gate.
  a_base_irq_gate: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && |i_base_limit_set && base_limit_irq_enable) |=> o_irq_req)
    else $error("base limit interrupt missing");

  // Calibration-failure gate.
  a_cal_irq_gate: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_cal_fail_set && cal_fail_irq_enable) |=> o_irq_req)
    else $error("calibration failure interrupt missing");

  // Gating off keeps full power.
  a_power_gate: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && idle_power_gate_off) |=> !o_low_power)
    else $error("reduced power while gating is off");

  // Last conversion enters low power.
  a_power_enter: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && !idle_power_gate_off && i_last_conv_done && !i_cycle_end) |=> o_low_power)
    else $error("reduced power not entered");

  // Retry follows the flag set.
  a_retry_follow: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce |=> (o_cal_retry == ($past(i_base_limit_set) & {6{$past(base_limit_recal_retry)}})))
    else $error("calibration retry mismatch");

  // Enable writes land next cycle.
  a_active_mirror: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_reg_wr && i_reg_addr == tsg_pkg::ACTIVE_INPUT_ENABLE_ADDR) |=> o_active_enable == $past(i_reg_wdata[5:0]))
    else $error("input enable write not applied");

  // Low-frequency noise blocks.
  a_lf_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && s.en[0] && i_conv_done[0] && i_lf_noise[0] && !lowfreq_filter_off) |=> o_delta[7:0] == 8'h00)
    else $error("low-frequency noise did not clear delta");

  // RF noise blocks.
  a_rf_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && s.en[0] && i_conv_done[0] && i_rf_noise[0] && !rf_filter_off) |=> o_delta[7:0] == 8'h00)
    else $error("RF noise did not clear delta");

  // RF-only noise reporting.
  a_noise_report: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && s.en[0] && i_conv_done[0] && i_lf_noise[0] && !i_rf_noise[0] && rf_only_noise_report)
    |=> !o_noise_status[0])
    else $error("low-frequency noise reported in RF-only mode");

  // Suppressed release stays quiet.
  a_release_quiet: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && release_irq_suppress && s.en[0] && i_conv_done[0] && s.touched[0]
      && ($signed(i_raw_delta[7:0]) <= $signed(i_touch_thr)) && !s.tick && i_conv_done[5:1] == 5'h00
      && i_base_limit_set == 6'h00 && !i_cal_fail_set) |=> !o_irq_req)
    else $error("release interrupt while suppressed");

  // Held-touch restart stays silent while disabled.
  a_hold_quiet: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && !held_touch_recal_enable)
    |=> o_hold_recal == 6'h00)
    else $error("hold restart while disabled");

  // A rising touch requests an interrupt.
  a_press_irq: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && !s.touched[0] && next_s.touched[0])
    |=> o_irq_req)
    else $error("press interrupt missing");

  // A release requests an interrupt unless suppressed.
  a_release_irq: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && !release_irq_suppress && s.en[0] && i_conv_done[0] && s.touched[0] && !next_s.touched[0])
    |=> o_irq_req)
    else $error("release interrupt missing");

  // With the noise threshold off every non-touch sample feeds recalibration.
  a_recal_all: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && digital_noise_threshold_off && s.en[0] && i_conv_done[0] && !next_s.touched[0])
    |=> o_recal_sample[0])
    else $error("recalibration sample missing");

  // With the noise threshold in use, samples above it are kept from recalibration.
  a_recal_skip: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && !digital_noise_threshold_off && s.en[0] && i_conv_done[0]
      && $signed(next_s.delta[0]) > $signed(i_noise_thr))
    |=> !o_recal_sample[0])
    else $error("noisy sample fed recalibration");

  // An excluded input never reports a touch.
  a_excluded_idle: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && !s.en[0])
    |=> !o_touch[0])
    else $error("excluded input touched");

  // The end of the sensing cycle restores full power.
  a_power_leave: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_cycle_end)
    |=> !o_low_power)
    else $error("reduced power past cycle end");

endmodule

// >>> tb/tsg_host_model.sv
`timescale 1ns/1ps
module tsg_host_model (
  input wire logic i_clk,        // System clock.
  output logic [7:0] o_addr,     // Register offset.
  output logic o_wr,             // Write strobe.
  output logic [7:0] o_wdata,    // Write data.
  output logic o_rd,             // Read strobe.
  input wire logic [7:0] i_rdata // Read data.
);
  // The host idles with both strobes low.
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end
  // A write holds its strobe over exactly one taking edge, then scrambles the data bus.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  // A read takes its data in the cycle after the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    d = i_rdata;
  endtask
endmodule

// >>> tb/touch_sensor_global_config_tb_top.sv
`timescale 1ns/1ps
module touch_sensor_global_config_tb_top;
  logic clk = 0, rstn = 0, ce = 1, scl = 1, sda = 1, wr, rd, brst, irq, lowp;
  logic [5:0] cd = 0, lf = 0, rf = 0, bls = 0, noise, touch, rs, hr, cr, ae;
  logic [8:6] evx = 0;
  logic [47:0] raw = 0, delta;
  logic [7:0] addr, wdata, rdata, d;
  logic [7:0] ra[5] = '{8'h20, 8'h21, 8'h22, 8'h44, 8'h23};
  logic [7:0] rv[5] = '{8'h20, 8'h3f, 8'ha4, 8'h40, 8'h00};
  logic [7:0] rm[5] = '{8'hb8, 8'h3f, 8'hff, 8'h7f, 8'h00};
  logic [7:0] fl[4] = '{8'h40, 8'h10, 8'h02, 8'h00};
  logic [31:0] s = 32'h01664dc2;
  int n_mismatch = 0, comparisons = 0, nb = 0, ni = 0, nh = 0, gc, gc2, e, p = 0;
  tsg_host_model host (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd), .i_rdata(rdata));
  tsg_top #(.P_MS_CYCLES(20), .P_LOW_CYCLES(50), .P_IDLE_CYCLES(30)) uut (
    .i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_scl(scl), .i_sda(sda), .o_bus_reset(brst), .i_conv_done(cd),
    .i_raw_delta(raw), .i_lf_noise(lf), .i_rf_noise(rf), .i_touch_thr(8'h20), .i_noise_thr(8'h10),
    .i_base_limit_set(bls), .i_cal_fail_set(evx[6]), .i_last_conv_done(evx[7]), .i_cycle_end(evx[8]),
    .o_delta(delta), .o_noise_status(noise), .o_touch(touch), .o_recal_sample(rs), .o_hold_recal(hr),
    .o_cal_retry(cr), .o_active_enable(ae), .o_irq_req(irq), .o_low_power(lowp));
  // Free-running 200 MHz clock.
  initial forever #2.5 clk = ~clk;
  // Pulses are counted on the falling edge, away from the edge that launches them.
  always @(negedge clk) begin
    if (brst === 1'b1) nb++;
    if (irq === 1'b1) ni++;
    if (hr[0] === 1'b1) nh++;
  end
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction
  task automatic chk(input logic [47:0] g, input logic [47:0] x);
    comparisons++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // One conversion strobe on input 1; outputs are settled when this returns.
  task automatic sense(input logic [7:0] r, input logic l, input logic f);
    @(posedge clk);
    #1;
    cd = 6'h01;
    raw[7:0] = r;
    lf[0] = l;
    rf[0] = f;
    @(posedge clk);
    #1;
    cd = 6'h00;
  endtask
  // One-cycle pulse on the flag and power event inputs.
  task automatic ev(input logic [8:0] w);
    @(posedge clk);
    #1;
    bls = w[5:0];
    evx = w[8:6];
    @(posedge clk);
    #1;
    bls = 6'h00;
    evx = 3'h0;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog sized well past the expected run.
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rstn = 1;
    repeat (3) @(posedge clk);
    // Reset values, then random writes read back through the writable masks.
    for (int i = 0; i < 5; i++) begin
      host.rd(ra[i], d);
      chk(d, rv[i]);
      s = nx(s);
      host.wr(ra[i], s[7:0]);
      host.rd(ra[i], d);
      chk(d, s[7:0] & rm[i]);
    end
    $display("test 1 done");
    // Random filter settings and deltas against the reference model.
    host.wr(8'h21, 8'h3f);
    for (int k = 0; k < 24; k++) begin
      s = nx(s);
      gc = int'(s[1:0]) << 4;
      gc2 = int'(s[7:4]) & 13;
      host.wr(8'h20, gc[7:0]);
      host.wr(8'h44, gc2[7:0]);
      sense(s[15:8], s[16], s[17]);
      e = ((lf[0] && !gc[4]) || (rf[0] && !gc2[2])) ? 0 : int'($signed(raw[7:0]));
      chk(delta[7:0], e[7:0]);
      chk(noise[0], rf[0] | (lf[0] & !gc2[3]));
      chk(touch[0], e > 32);
      chk(rs[0], !(e > 32) && (gc[5] || e <= 16));
      chk(irq, (e > 32 && p == 0) || (!(e > 32) && p == 1 && !gc2[0]));
      p = (e > 32) ? 1 : 0;
    end
    $display("test 2 done");
    // A write while the clock enable is low is not taken.
    ce = 0;
    host.wr(8'h21, 8'h00);
    ce = 1;
    chk(ae, 6'h3f);
    // A disabled input never reports a touch.
    host.wr(8'h21, 8'h3e);
    chk(ae, 6'h3e);
    sense(8'h7f, 1'b0, 1'b0);
    chk(touch[0], 1'b0);
    host.wr(8'h21, 8'h3f);
    // Shortest repeat interval: two repeats within 1410 cycles of a press.
    host.wr(8'h22, 8'h00);
    host.wr(8'h44, 8'h00);
    sense(8'h7f, 1'b0, 1'b0);
    #3;
    ni = 0;
    repeat (1410) @(posedge clk);
    chk(ni, 2);
    // The held touch restarts recalibration once, just past the shortest maximum duration.
    host.wr(8'h20, 8'h08);
    nh = 0;
    repeat (9550) @(posedge clk);
    chk(nh, 0);
    repeat (300) @(posedge clk);
    chk(nh, 1);
    sense(8'h00, 1'b0, 1'b0);
    $display("test 3 done");
    // Flag events with retry, base-limit enable, calibration-failure enable, or nothing set.
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h44, fl[i]);
      ev(9'h004);
      chk(cr, fl[i][6] ? 6'h04 : 6'h00);
      chk(irq, fl[i][4]);
      ev(9'h040);
      chk(irq, fl[i][1]);
    end
    // Reduced power only while gating is allowed.
    for (int b = 0; b < 2; b++) begin
      host.wr(8'h44, b ? 8'h20 : 8'h00);
      ev(9'h080);
      chk(lowp, b == 0);
      ev(9'h100);
      chk(lowp, 1'b0);
    end
    $display("test 4 done");
    // Line watch off: neither a low clock nor an idle bus resets the interface.
    host.wr(8'h20, 8'h00);
    nb = 0;
    scl = 0;
    repeat (120) @(posedge clk);
    chk(nb, 0);
    #1;
    scl = 1;
    repeat (120) @(posedge clk);
    chk(nb, 0);
    // Line watch on: one reset per static stretch, none while data toggles under a low clock.
    host.wr(8'h20, 8'h80);
    #1;
    scl = 0;
    nb = 0;
    repeat (40) @(posedge clk);
    chk(nb, 0);
    repeat (40) @(posedge clk);
    chk(nb, 1);
    #1;
    scl = 1;
    nb = 0;
    repeat (100) @(posedge clk);
    chk(nb, 1);
    nb = 0;
    for (int t = 0; t < 8; t++) begin
      #1;
      scl = 1'b0;
      sda = ~sda;
      repeat (20) @(posedge clk);
    end
    chk(nb, 0);
    $display("test 5 done");
    report_and_stop();
  end
endmodule
